//--- dv/msirq_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host controller model: drives the register port
// ----------------------------------------------------------------
module msirq_host_model
    import msirq_pkg::*;
(
    input  wire logic         clk,
    output msirq_bus_req_t    bus_req,
    input  wire msirq_word_t  rdata
);

    initial bus_req = '0;

    // ----------------------------------------------------------------
    // One-cycle write strobe
    // ----------------------------------------------------------------
    task automatic reg_write(input msirq_addr_t a, input msirq_word_t d);
        @(posedge clk);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge clk);
        bus_req.wr    <= 1'b0;
        // Released lines flip so a stale value is never mistaken for a live one
        bus_req.addr  <= ~a;
        bus_req.wdata <= ~d;
    endtask : reg_write

    // ----------------------------------------------------------------
    // One-cycle read strobe, data taken in the following cycle
    // ----------------------------------------------------------------
    task automatic reg_read(input msirq_addr_t a, output msirq_word_t d);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge clk);
        bus_req.rd   <= 1'b0;
        bus_req.addr <= ~a;
        #1;
        d = rdata;
    endtask : reg_read

endmodule : msirq_host_model

//--- dv/msirq_tb.sv
`timescale 1ns/1ps

module testbench
    import msirq_pkg::*;
;
    localparam int HOLD = 4;

    logic               clk;
    logic               resetn;
    msirq_bus_req_t     bus_req;
    msirq_word_t        rdata;
    msirq_first_cond_t  cond_first;
    msirq_second_cond_t cond_second;
    logic               irq_first;
    logic               irq_second;
    logic               warn;
    logic               dsr;
    int                 err_count;
    int                 checked;
    int                 n;
    msirq_word_t        rd_val;
    msirq_word_t        exp;
    int                 pos_tab [8] = '{14, 12, 10, 8, 7, 6, 3, 2};

    initial clk = 1'b0;
    always #4 clk = ~clk;

    msirq_top #(.SRST_HOLD(HOLD)) DUT (
        .clk                  (clk),
        .resetn               (resetn),
        .bus_req              (bus_req),
        .rdata                (rdata),
        .cond_first           (cond_first),
        .cond_second          (cond_second),
        .interrupt_out_first  (irq_first),
        .interrupt_out_second (irq_second),
        .warning_out          (warn),
        .device_soft_reset    (dsr)
    );

    msirq_host_model host (
        .clk     (clk),
        .bus_req (bus_req),
        .rdata   (rdata)
    );

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : chk

    task automatic rd_chk(input msirq_addr_t a, input msirq_word_t want);
        host.reg_read(a, rd_val);
        chk(rd_val, want);
    endtask : rd_chk

    task automatic pins_chk(input logic i1, input logic i2, input logic w);
        chk({13'h0, irq_first, irq_second, warn}, {13'h0, i1, i2, w});
    endtask : pins_chk

    // Conditions held for exactly one cycle, so any later flag must be sticky
    task automatic pulse(input msirq_first_cond_t f, input msirq_second_cond_t s);
        @(posedge clk);
        cond_first  <= f;
        cond_second <= s;
        @(posedge clk);
        cond_first  <= '0;
        cond_second <= '0;
        #1;
    endtask : pulse

    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        cond_first  = '0;
        cond_second = '0;
        resetn      = 1'b0;
        err_count   = 0;
        checked     = 0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        #1;
        pins_chk(1'b0, 1'b0, 1'b0);
        for (int a = 0; a < 5; a++) begin
            rd_chk(9'(a), 16'h0000);
        end
        host.reg_write(9'h1ff, 16'hffff);
        rd_chk(9'h1ff, 16'h0000);
        host.reg_write(9'h001, 16'hffff);
        rd_chk(9'h001, 16'h0000);
        host.reg_write(9'h003, 16'hffff);
        rd_chk(9'h003, 16'h04cc);
        host.reg_write(9'h004, 16'hffff);
        rd_chk(9'h004, 16'hceff);
        // Each first-status source alone; checksum flags warn regardless of enables
        for (int i = 0; i < 8; i++) begin
            pulse(msirq_first_cond_t'(8'h80 >> i), '0);
            exp = 16'h0001 << pos_tab[i];
            pins_chk((exp & 16'h04cc) != 16'h0, 1'b0, (exp & 16'h5500) != 16'h0);
            repeat (3) @(posedge clk);
            rd_chk(9'h001, exp);
            pins_chk(1'b0, 1'b0, 1'b0);
            rd_chk(9'h001, 16'h0000);
        end
        pulse('1, '0);
        rd_chk(9'h001, 16'h55cc);
        // Dropping the enable releases the interrupt but not the warning
        pulse(msirq_first_cond_t'(8'h42), '0);
        pins_chk(1'b1, 1'b0, 1'b1);
        host.reg_write(9'h003, 16'h0000);
        @(posedge clk);
        #1;
        pins_chk(1'b0, 1'b0, 1'b1);
        rd_chk(9'h001, 16'h1008);
        host.reg_write(9'h003, 16'h04cc);
        // Second status and its interrupt
        pulse('0, '1);
        pins_chk(1'b0, 1'b1, 1'b0);
        rd_chk(9'h002, 16'hceff);
        pins_chk(1'b0, 1'b0, 1'b0);
        rd_chk(9'h002, 16'h0000);
        host.reg_write(9'h004, 16'h0000);
        pulse('0, msirq_second_cond_t'(13'h0100));
        pins_chk(1'b0, 1'b0, 1'b0);
        rd_chk(9'h002, 16'h0200);
        // Soft reset: wrong key first, then the key with a flag pending
        host.reg_write(9'h000, 16'h789b);
        @(posedge clk);
        #1;
        chk({15'h0, dsr}, 16'h0000);
        rd_chk(9'h003, 16'h04cc);
        rd_chk(9'h000, 16'h0000);
        pulse(msirq_first_cond_t'(8'h01), '0);
        pins_chk(1'b1, 1'b0, 1'b0);
        host.reg_write(9'h000, 16'h789a);
        #1;
        chk({15'h0, dsr}, 16'h0001);
        n = 0;
        while (dsr === 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(16'(n), 16'(HOLD));
        pins_chk(1'b0, 1'b0, 1'b0);
        rd_chk(9'h003, 16'h0000);
        rd_chk(9'h001, 16'h0000);
        // Hardware reset in mid-run must clear the same state as the key
        host.reg_write(9'h004, 16'hffff);
        pulse('0, msirq_second_cond_t'(13'h1000));
        pins_chk(1'b0, 1'b1, 1'b0);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1;
        pins_chk(1'b0, 1'b0, 1'b0);
        rd_chk(9'h004, 16'h0000);
        rd_chk(9'h002, 16'h0000);
        report_and_stop();
    end

endmodule : testbench

//--- logic/msirq_defs.svh
`ifndef MSIRQ_DEFS_SVH
`define MSIRQ_DEFS_SVH

// ----------------------------------------------------------------
// Register port geometry
// ----------------------------------------------------------------
`define MSIRQ_AW          9
`define MSIRQ_DW          16

// ----------------------------------------------------------------
// Register offsets (word index)
// ----------------------------------------------------------------
`define MSIRQ_OFF_SRST    9'h000
`define MSIRQ_OFF_STAT0   9'h001
`define MSIRQ_OFF_STAT1   9'h002
`define MSIRQ_OFF_EN0     9'h003
`define MSIRQ_OFF_EN1     9'h004

// ----------------------------------------------------------------
// Values and masks
// ----------------------------------------------------------------
`define MSIRQ_SRST_KEY    16'h789a
`define MSIRQ_RST_VAL     16'h0000
`define MSIRQ_STAT0_MASK  16'h55cc
`define MSIRQ_EN0_MASK    16'h04cc
`define MSIRQ_STAT1_MASK  16'hceff
`define MSIRQ_EN1_MASK    16'hceff
`define MSIRQ_CS_MASK     16'h5500

// ----------------------------------------------------------------
// First status field positions
// ----------------------------------------------------------------
`define MSIRQ_B_CS0       14
`define MSIRQ_B_CS1       12
`define MSIRQ_B_CS2       10
`define MSIRQ_B_CS3       8
`define MSIRQ_B_VSEQ      7
`define MSIRQ_B_ISEQ      6
`define MSIRQ_B_SAG       3
`define MSIRQ_B_PLOSS     2

// ----------------------------------------------------------------
// Second status field positions
// ----------------------------------------------------------------
`define MSIRQ_B_NOV1      15
`define MSIRQ_B_NOV0      14
`define MSIRQ_B_THDU      11
`define MSIRQ_B_THDI      10
`define MSIRQ_B_DFT       9
`define MSIRQ_B_DIR_HI    7
`define MSIRQ_B_DIR_LO    0

// ----------------------------------------------------------------
// Soft reset hold length in clock cycles
// ----------------------------------------------------------------
`define MSIRQ_SRST_HOLD   4

`endif

//--- logic/msirq_pkg.sv
`include "msirq_defs.svh"

package msirq_pkg;

    // ----------------------------------------------------------------
    // Basic words
    // ----------------------------------------------------------------
    typedef logic [`MSIRQ_AW-1:0] msirq_addr_t;
    typedef logic [`MSIRQ_DW-1:0] msirq_word_t;

    // ----------------------------------------------------------------
    // Register port request
    // ----------------------------------------------------------------
    typedef struct packed {
        msirq_addr_t addr;
        msirq_word_t wdata;
        logic        wr;
        logic        rd;
    } msirq_bus_req_t;

    // ----------------------------------------------------------------
    // Condition levels from the measurement logic
    // ----------------------------------------------------------------
    typedef struct packed {
        logic checksum_first_error;
        logic checksum_second_error;
        logic checksum_third_error;
        logic checksum_fourth_error;
        logic voltage_sequence_error;
        logic current_sequence_error;
        logic voltage_sag_flag;
        logic phase_loss_flag;
    } msirq_first_cond_t;

    typedef struct packed {
        logic       nline_sampled_over;
        logic       nline_calc_over;
        logic       thd_voltage_over;
        logic       thd_current_over;
        logic       transform_done;
        logic [7:0] energy_dir_change;
    } msirq_second_cond_t;

    // ----------------------------------------------------------------
    // Soft reset sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MSIRQ_ST_IDLE = 2'b01,
        MSIRQ_ST_HOLD = 2'b10
    } msirq_srst_state_t;

endpackage : msirq_pkg

//--- logic/msirq_rst_gen.sv
`timescale 1ns/1ps
`include "msirq_defs.svh"

module msirq_rst_gen
    import msirq_pkg::*;
#(
    parameter int HOLD = `MSIRQ_SRST_HOLD
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic trigger,
    output logic      srst_active
);

    localparam int CW = $clog2(HOLD + 1);

    msirq_srst_state_t state_q;
    msirq_srst_state_t state_d;
    logic [CW-1:0]     cnt_q;
    logic [CW-1:0]     cnt_d;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            MSIRQ_ST_IDLE: begin
                if (trigger) begin
                    state_d = MSIRQ_ST_HOLD;
                    cnt_d   = CW'(HOLD - 1);
                end
            end
            MSIRQ_ST_HOLD: begin
                if (cnt_q == '0) begin
                    state_d = MSIRQ_ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = MSIRQ_ST_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= MSIRQ_ST_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign srst_active = (state_q == MSIRQ_ST_HOLD);

endmodule : msirq_rst_gen

//--- logic/msirq_top.sv
// Summary of operation
// - Only a write of the key to offset zero starts a full reset.
// - Soft reset restores every register to default, like the hardware reset.
// - Reading the soft reset register always returns zero.
// - First interrupt is high while any enabled first-status flag is set.
// - Second interrupt is high while any enabled second-status flag is set.
// - Bit 14 flags a checksum error on the first configuration group.
// - Bit 12 flags a checksum error on the second configuration group.
// - Bit 10 flags a checksum error on the third configuration group.
// - Bit 8 flags a checksum error on the fourth configuration group.
// - Any checksum error flag raises the warning pin in the same cycle.
// - Bit 7 flags a wrong voltage phase sequence.
// - Bit 6 flags a wrong current phase sequence.
// - Bit 3 flags voltage sag on one or more phases.
// - Bit 2 flags loss of one or more voltage phases.
// - First status resets to zero and a host read returns then clears it.
// - First enable register resets to zero, enables at bits 10, 7, 6, 3, 2.
// - Second status resets to zero, clears on read, holds its event flags.
`timescale 1ns/1ps
`include "msirq_defs.svh"

module msirq_top
    import msirq_pkg::*;
#(
    parameter int SRST_HOLD = `MSIRQ_SRST_HOLD
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire msirq_bus_req_t     bus_req,
    output msirq_word_t             rdata,
    input  wire msirq_first_cond_t  cond_first,
    input  wire msirq_second_cond_t cond_second,
    output logic                    interrupt_out_first,
    output logic                    interrupt_out_second,
    output logic                    warning_out,
    output logic                    device_soft_reset
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic addr_hit(input msirq_addr_t a, input msirq_addr_t off);
        return a == off;
    endfunction : addr_hit

    function automatic msirq_word_t pack_first(input msirq_first_cond_t c);
        msirq_word_t w;
        w                 = `MSIRQ_RST_VAL;
        w[`MSIRQ_B_CS0]   = c.checksum_first_error;
        w[`MSIRQ_B_CS1]   = c.checksum_second_error;
        w[`MSIRQ_B_CS2]   = c.checksum_third_error;
        w[`MSIRQ_B_CS3]   = c.checksum_fourth_error;
        w[`MSIRQ_B_VSEQ]  = c.voltage_sequence_error;
        w[`MSIRQ_B_ISEQ]  = c.current_sequence_error;
        w[`MSIRQ_B_SAG]   = c.voltage_sag_flag;
        w[`MSIRQ_B_PLOSS] = c.phase_loss_flag;
        return w;
    endfunction : pack_first

    function automatic msirq_word_t pack_second(input msirq_second_cond_t c);
        msirq_word_t w;
        w                                   = `MSIRQ_RST_VAL;
        w[`MSIRQ_B_NOV1]                    = c.nline_sampled_over;
        w[`MSIRQ_B_NOV0]                    = c.nline_calc_over;
        w[`MSIRQ_B_THDU]                    = c.thd_voltage_over;
        w[`MSIRQ_B_THDI]                    = c.thd_current_over;
        w[`MSIRQ_B_DFT]                     = c.transform_done;
        w[`MSIRQ_B_DIR_HI:`MSIRQ_B_DIR_LO]  = c.energy_dir_change;
        return w;
    endfunction : pack_second

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    msirq_word_t stat0_q;
    msirq_word_t stat0_d;
    msirq_word_t stat1_q;
    msirq_word_t stat1_d;
    msirq_word_t en0_q;
    msirq_word_t en0_d;
    msirq_word_t en1_q;
    msirq_word_t en1_d;
    msirq_word_t rdata_q;
    msirq_word_t rdata_d;
    logic        interrupt_out_first_q;
    logic        interrupt_out_first_d;
    logic        interrupt_out_second_q;
    logic        interrupt_out_second_d;
    logic        warn_q;
    logic        warn_d;
    msirq_word_t cond0;
    msirq_word_t cond1;
    logic        key_hit;
    logic        clr0;
    logic        clr1;
    logic        srst_active;

    // ----------------------------------------------------------------
    // Soft reset sequencer
    // ----------------------------------------------------------------
    msirq_rst_gen #(
        .HOLD        (SRST_HOLD)
    ) u_rst_gen (
        .clk         (clk),
        .resetn      (resetn),
        .trigger     (key_hit),
        .srst_active (srst_active)
    );

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    always_comb begin
        cond0   = pack_first(cond_first);
        cond1   = pack_second(cond_second);
        // Writes during the hold are dropped so a repeated key cannot stretch it
        key_hit = bus_req.wr && addr_hit(bus_req.addr, `MSIRQ_OFF_SRST)
                  && (bus_req.wdata == `MSIRQ_SRST_KEY) && !srst_active;
        clr0    = bus_req.rd && addr_hit(bus_req.addr, `MSIRQ_OFF_STAT0);
        clr1    = bus_req.rd && addr_hit(bus_req.addr, `MSIRQ_OFF_STAT1);
        stat0_d = stat0_q;
        stat1_d = stat1_q;
        en0_d   = en0_q;
        en1_d   = en1_q;
        rdata_d = `MSIRQ_RST_VAL;
        if (srst_active) begin
            // Conditions are ignored for the whole hold; they re-latch after it
            stat0_d = `MSIRQ_RST_VAL;
            stat1_d = `MSIRQ_RST_VAL;
            en0_d   = `MSIRQ_RST_VAL;
            en1_d   = `MSIRQ_RST_VAL;
        end else begin
            // A condition present in the clearing cycle wins over the clear
            stat0_d = (cond0 | (stat0_q & ~{`MSIRQ_DW{clr0}})) & `MSIRQ_STAT0_MASK;
            stat1_d = (cond1 | (stat1_q & ~{`MSIRQ_DW{clr1}})) & `MSIRQ_STAT1_MASK;
            if (bus_req.wr && addr_hit(bus_req.addr, `MSIRQ_OFF_EN0)) begin
                en0_d = bus_req.wdata & `MSIRQ_EN0_MASK;
            end
            if (bus_req.wr && addr_hit(bus_req.addr, `MSIRQ_OFF_EN1)) begin
                en1_d = bus_req.wdata & `MSIRQ_EN1_MASK;
            end
            if (bus_req.rd) begin
                unique case (bus_req.addr)
                    `MSIRQ_OFF_SRST:  rdata_d = `MSIRQ_RST_VAL;
                    `MSIRQ_OFF_STAT0: rdata_d = stat0_q;
                    `MSIRQ_OFF_STAT1: rdata_d = stat1_q;
                    `MSIRQ_OFF_EN0:   rdata_d = en0_q;
                    `MSIRQ_OFF_EN1:   rdata_d = en1_q;
                    default:          rdata_d = `MSIRQ_RST_VAL;
                endcase
            end
        end
        // Pins follow the flags in the cycle they land, so no extra latency
        interrupt_out_first_d = |(stat0_d & en0_d);
        interrupt_out_second_d = |(stat1_d & en1_d);
        warn_d = |(stat0_d & `MSIRQ_CS_MASK);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat0_q <= `MSIRQ_RST_VAL;
            stat1_q <= `MSIRQ_RST_VAL;
            en0_q   <= `MSIRQ_RST_VAL;
            en1_q   <= `MSIRQ_RST_VAL;
            rdata_q <= `MSIRQ_RST_VAL;
            interrupt_out_first_q  <= 1'b0;
            interrupt_out_second_q  <= 1'b0;
            warn_q  <= 1'b0;
        end else begin
            stat0_q <= stat0_d;
            stat1_q <= stat1_d;
            en0_q   <= en0_d;
            en1_q   <= en1_d;
            rdata_q <= rdata_d;
            interrupt_out_first_q  <= interrupt_out_first_d;
            interrupt_out_second_q  <= interrupt_out_second_d;
            warn_q  <= warn_d;
        end
    end

    assign rdata                = rdata_q;
    assign interrupt_out_first  = interrupt_out_first_q;
    assign interrupt_out_second = interrupt_out_second_q;
    assign warning_out          = warn_q;
    assign device_soft_reset    = srst_active;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!resetn);

    sequence key_write_s;
        bus_req.wr && (bus_req.addr == `MSIRQ_OFF_SRST) && (bus_req.wdata == `MSIRQ_SRST_KEY) && !srst_active;
    endsequence

    sequence hold_s;
        srst_active [*4];
    endsequence

    sequence bad_key_s;
        bus_req.wr && (bus_req.addr == `MSIRQ_OFF_SRST) && (bus_req.wdata != `MSIRQ_SRST_KEY) && !srst_active;
    endsequence

    srst_start_a: assert property (key_write_s |=> hold_s ##1 !srst_active)
        else $error("Key write did not give a four cycle soft reset");

    srst_ignore_a: assert property (bad_key_s |=> !srst_active)
        else $error("Soft reset started without the key");

    srst_clear_a: assert property (key_write_s ##1 hold_s |->
                                   (stat0_q == 16'h0000) && (stat1_q == 16'h0000)
                                   && (en0_q == 16'h0000) && (en1_q == 16'h0000)
                                   && !interrupt_out_first && !warning_out)
        else $error("Registers not at default after soft reset");

    srst_read_a: assert property (bus_req.rd && (bus_req.addr == `MSIRQ_OFF_SRST) |=> rdata == 16'h0000)
        else $error("Soft reset register read not zero");

    irq_first_a: assert property (((stat0_q & en0_q) != 16'h0000) == interrupt_out_first)
        else $error("First interrupt does not match enabled flags");

    irq_second_a: assert property (((stat1_q & en1_q) != 16'h0000) == interrupt_out_second)
        else $error("Second interrupt does not match enabled flags");

    cs_flags_a: assert property (!srst_active && cond_first.checksum_first_error
                                 |=> stat0_q[`MSIRQ_B_CS0] && warning_out)
        else $error("First checksum error not flagged");

    cs_group_a: assert property (!srst_active && (cond_first.checksum_second_error
                                 || cond_first.checksum_third_error || cond_first.checksum_fourth_error)
                                 |=> (stat0_q[`MSIRQ_B_CS1] || stat0_q[`MSIRQ_B_CS2] || stat0_q[`MSIRQ_B_CS3])
                                 && warning_out)
        else $error("Checksum error flag or warning missing");

    warn_rise_a: assert property ($rose(|(stat0_q & `MSIRQ_CS_MASK)) |-> warning_out)
        else $error("Warning not raised with checksum flag");

    seq_flags_a: assert property (!srst_active |=> (stat0_q & $past(cond0) & ~`MSIRQ_CS_MASK)
                                  == ($past(cond0) & ~`MSIRQ_CS_MASK))
        else $error("Phase condition not flagged");

    read_clear_a: assert property (bus_req.rd && (bus_req.addr == `MSIRQ_OFF_STAT0) && (cond0 == 16'h0000)
                                   && !srst_active |=> (stat0_q == 16'h0000) && !interrupt_out_first)
        else $error("First status not cleared by read");

    read_value_a: assert property (bus_req.rd && (bus_req.addr == `MSIRQ_OFF_STAT0) && !srst_active
                                   |=> rdata == $past(stat0_q))
        else $error("First status read value wrong");

    rsvd_zero_a: assert property ((stat0_q & ~`MSIRQ_STAT0_MASK) == 16'h0000)
        else $error("Reserved first status bit set");

    en_write_a: assert property (bus_req.wr && (bus_req.addr == `MSIRQ_OFF_EN0) && !srst_active
                                 |=> en0_q == ($past(bus_req.wdata) & `MSIRQ_EN0_MASK))
        else $error("First enable write not stored");

    stat1_clear_a: assert property (bus_req.rd && (bus_req.addr == `MSIRQ_OFF_STAT1) && (cond1 == 16'h0000)
                                    && !srst_active |=> stat1_q == 16'h0000)
        else $error("Second status not cleared by read");

    sticky_a: assert property (!srst_active && !(bus_req.rd && (bus_req.addr == `MSIRQ_OFF_STAT0))
                               |=> (stat0_q & $past(stat0_q)) == $past(stat0_q))
        else $error("First status flag lost without a read");

    warn_level_a: assert property (warning_out == ((stat0_q & `MSIRQ_CS_MASK) != 16'h0000))
        else $error("Warning does not follow the checksum flags");

    rdata_idle_a: assert property (!bus_req.rd |=> rdata == 16'h0000)
        else $error("Read data not zero outside a read");

    set_wins_a: assert property (bus_req.rd && (bus_req.addr == `MSIRQ_OFF_STAT0) && !srst_active
                                 |=> (stat0_q & $past(cond0)) == $past(cond0))
        else $error("Condition lost in the clearing cycle");

    stat1_value_a: assert property (bus_req.rd && (bus_req.addr == `MSIRQ_OFF_STAT1) && !srst_active
                                    |=> rdata == $past(stat1_q))
        else $error("Second status read value wrong");

    stat1_set_a: assert property (!srst_active |=> (stat1_q & $past(cond1)) == $past(cond1))
        else $error("Second status condition not flagged");

    en1_write_a: assert property (bus_req.wr && (bus_req.addr == `MSIRQ_OFF_EN1) && !srst_active
                                  |=> en1_q == ($past(bus_req.wdata) & `MSIRQ_EN1_MASK))
        else $error("Second enable write not stored");

    srst_busy_a: assert property (srst_active && $past(srst_active)
                                  |-> !interrupt_out_first && !interrupt_out_second && !warning_out
                                  && (rdata == 16'h0000))
        else $error("Pins or read data active during soft reset");

    srst_write_a: assert property (srst_active && bus_req.wr |=> (en0_q == 16'h0000) && (en1_q == 16'h0000))
        else $error("Write accepted during soft reset");

    en_rsvd_a: assert property ((en0_q & ~`MSIRQ_EN0_MASK) == 16'h0000)
        else $error("Reserved first enable bit set");

endmodule : msirq_top
